// File: src/rtc_nv_config_and_user_ram.sv
// Overview of operation
// - settings byte: trickle, clock select, thermometer
// - each trickle resistor follows its bit
// - offset bit 7 is sign, one fast
// - offset bits 6..0 magnitude, 0 to 121
// - full 8-bit quadratic coefficient to compensation
// - turnover temperature bits 5..0, 7..6 unused
// - eight user RAM bytes 38h..3Fh
// - run from higher supply, 20 mV hysteresis
// - low-supply interrupts only when enabled
// - low supply at the upper threshold disables the thermometer
// - backup mode disables interface and clock output
// - bits 3..2 select clock output frequency
// - bit 1 enables thermometer, else temperature writable
// - bit 0 picks 1 s or 16 s period
// - load configuration from page after power-up
`timescale 1ns/1ps
module rtc_nv_config_and_user_ram
	import rtc_nv_config_pkg::*;
#(
	parameter int CyclesPerSecond = CYCLES_PER_SECOND
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire nv_page_s nvPage,
	input wire logic [SUPPLY_MV_W-1:0] mainSupplyMv,
	input wire logic [SUPPLY_MV_W-1:0] backupSupplyMv,
	input wire logic supplyLowUpperThreshold,
	input wire logic supplyLowLowerThreshold,
	input wire logic lowUpperIntEnable,
	input wire logic lowLowerIntEnable,
	output logic [3:0] trickleResEn,
	output logic [1:0] clkoutFreqSel,
	output logic clockOutputEnable,
	output logic hostIfEnable,
	output logic onBackup,
	output logic thermometerEnable,
	output logic temperatureWritable,
	output logic monitorTick,
	output comp_params_s compParams,
	output logic lowUpperIrq,
	output logic lowLowerIrq,
	output logic configLoaded
);

	// ===============================
	// storage
	logic [7:0] settings_reg;
	logic [7:0] offset_reg;
	logic [7:0] quadCoef_reg;
	logic [TURNOVER_W-1:0] turnover_reg;
	logic [7:0] userRam [USER_RAM_WORDS];
	load_state_e load_reg;
	logic onBackup_reg;
	logic [7:0] rdData_reg;
	logic [31:0] secCount_reg;
	logic [4:0] periodCount_reg;
	logic tick_reg;
	logic [3:0] trickle_reg;
	logic [1:0] clkSel_reg;
	logic clkOutEn_reg;
	logic hostIf_reg;
	logic thermoEn_reg;
	logic tempWr_reg;
	comp_params_s comp_reg;
	logic upperIrq_reg;
	logic lowerIrq_reg;
	logic loaded_reg;
	logic hostWrite;
	logic hostRead;
	logic ramHit;
	logic [USER_RAM_INDEX_W-1:0] ramIndex;
	logic loadNow;
	logic [12:0] mainPlusHyst;
	logic [12:0] backupPlusHyst;
	logic [4:0] periodSeconds;
	logic secondPulse;
	// interface frozen in backup mode
	assign hostWrite = regWrite & ~onBackup_reg;
	assign hostRead = regRead & ~onBackup_reg;
	assign ramHit = (regAddr[7:3] == ADDR_USER_RAM_PAGE);
	assign ramIndex = regAddr[USER_RAM_INDEX_W-1:0];
	assign loadNow = (load_reg == LOAD_COPY);

	// ===============================
	// power-up load sequence
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			load_reg <= LOAD_WAIT;
		else
			unique case (load_reg)
				LOAD_WAIT:
					if (!supplyLowUpperThreshold)
						load_reg <= LOAD_COPY;
				LOAD_COPY:
					load_reg <= LOAD_DONE;
				LOAD_DONE:
					load_reg <= LOAD_DONE;
				default:
					load_reg <= LOAD_WAIT;
			endcase
	end

	// ===============================
	// configuration registers, page load wins over a host write
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			settings_reg <= SETTINGS_RESET;
			offset_reg <= BYTE_RESET;
			quadCoef_reg <= BYTE_RESET;
			turnover_reg <= '0;
		end
		else if (loadNow)
		begin
			settings_reg <= nvPage.settings;
			offset_reg <= nvPage.offset;
			quadCoef_reg <= nvPage.quadCoef;
			turnover_reg <= nvPage.turnover[TURNOVER_W-1:0];
		end
		else if (hostWrite)
		begin
			// calibration bytes stay writable; no lock
			unique case (regAddr)
				ADDR_NV_SETTINGS: settings_reg <= regWrData;
				ADDR_CRYSTAL_OFFSET: offset_reg <= regWrData;
				ADDR_CRYSTAL_QUAD_COEF: quadCoef_reg <= regWrData;
				ADDR_CRYSTAL_TURNOVER_TEMP: turnover_reg <= regWrData[TURNOVER_W-1:0];
				default: ;
			endcase
		end
	end

	// ===============================
	// user RAM
	always_ff @(posedge clk)
	begin
		if (hostWrite && ramHit)
			userRam[ramIndex] <= regWrData;
	end

	// ===============================
	// read port
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rdData_reg <= READ_UNMAPPED;
		else if (hostRead)
		begin
			if (ramHit)
				rdData_reg <= userRam[ramIndex];
			else
			begin
				unique case (regAddr)
					ADDR_NV_SETTINGS: rdData_reg <= settings_reg;
					ADDR_CRYSTAL_OFFSET: rdData_reg <= offset_reg;
					ADDR_CRYSTAL_QUAD_COEF: rdData_reg <= quadCoef_reg;
					ADDR_CRYSTAL_TURNOVER_TEMP: rdData_reg <= {2'b00, turnover_reg};
					default: rdData_reg <= READ_UNMAPPED;
				endcase
			end
		end
	end

	// ===============================
	// supply switchover with hysteresis
	assign mainPlusHyst = {1'b0, mainSupplyMv} + SWITCH_HYST_MV;
	assign backupPlusHyst = {1'b0, backupSupplyMv} + SWITCH_HYST_MV;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			onBackup_reg <= 1'b0;
		else if (!onBackup_reg && ({1'b0, backupSupplyMv} > mainPlusHyst))
			onBackup_reg <= 1'b1;
		else if (onBackup_reg && ({1'b0, mainSupplyMv} > backupPlusHyst))
			onBackup_reg <= 1'b0;
	end

	// ===============================
	// monitoring period divider
	assign periodSeconds = settings_reg[THERMO_PERIOD_BIT] ? MONITOR_LONG_S : MONITOR_SHORT_S;
	assign secondPulse = (secCount_reg == 32'(CyclesPerSecond - 1));
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			secCount_reg <= '0;
		else if (secondPulse)
			secCount_reg <= '0;
		else
			secCount_reg <= secCount_reg + 32'h00000001;
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			periodCount_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= 1'b0;
			if (secondPulse)
			begin
				if (periodCount_reg + 5'h01 >= periodSeconds)
				begin
					periodCount_reg <= '0;
					tick_reg <= 1'b1;
				end
				else
					periodCount_reg <= periodCount_reg + 5'h01;
			end
		end
	end

	// ===============================
	// derived controls
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trickle_reg <= '0;
			clkSel_reg <= '0;
			clkOutEn_reg <= 1'b0;
			hostIf_reg <= 1'b0;
			thermoEn_reg <= 1'b0;
			tempWr_reg <= 1'b0;
			loaded_reg <= 1'b0;
		end
		else
		begin
			trickle_reg <= settings_reg[TRICKLE_MSB:TRICKLE_LSB];
			clkSel_reg <= settings_reg[CLOCK_OUTPUT_PIN_SEL_MSB:CLOCK_OUTPUT_PIN_SEL_LSB];
			clkOutEn_reg <= ~onBackup_reg;
			hostIf_reg <= ~onBackup_reg;
			// thermometer needs the upper supply level
			thermoEn_reg <= settings_reg[THERMO_EN_BIT] & ~supplyLowUpperThreshold;
			tempWr_reg <= ~settings_reg[THERMO_EN_BIT];
			loaded_reg <= (load_reg == LOAD_DONE);
		end
	end

	// ===============================
	// compensation parameters
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			comp_reg <= '0;
		else
		begin
			comp_reg.offsetFast <= offset_reg[OFFSET_SIGN_BIT];
			// magnitude outside its range is clamped
			comp_reg.offsetMag <= (offset_reg[6:0] > OFFSET_MAG_MAX) ? OFFSET_MAG_MAX : offset_reg[6:0];
			comp_reg.quadCoef <= quadCoef_reg;
			comp_reg.turnoverTemperature <= turnover_reg;
		end
	end

	// ===============================
	// low supply interrupt requests
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			upperIrq_reg <= 1'b0;
			lowerIrq_reg <= 1'b0;
		end
		else
		begin
			upperIrq_reg <= supplyLowUpperThreshold & lowUpperIntEnable;
			lowerIrq_reg <= supplyLowLowerThreshold & lowLowerIntEnable;
		end
	end
	assign regRdData = rdData_reg;
	assign trickleResEn = trickle_reg;
	assign clkoutFreqSel = clkSel_reg;
	assign clockOutputEnable = clkOutEn_reg;
	assign hostIfEnable = hostIf_reg;
	assign onBackup = onBackup_reg;
	assign thermometerEnable = thermoEn_reg;
	assign temperatureWritable = tempWr_reg;
	assign monitorTick = tick_reg;
	assign compParams = comp_reg;
	assign lowUpperIrq = upperIrq_reg;
	assign lowLowerIrq = lowerIrq_reg;
	assign configLoaded = loaded_reg;
	// ===============================
	// assertions
	trickle_follow_a: assert property (@(posedge clk) disable iff (!resetn)
		##1 trickleResEn == $past(settings_reg[TRICKLE_MSB:TRICKLE_LSB]))
		else $error("trickle enables differ from settings");
	clock_output_pin_sel_a: assert property (@(posedge clk) disable iff (!resetn)
		##1 clkoutFreqSel == $past(settings_reg[CLOCK_OUTPUT_PIN_SEL_MSB:CLOCK_OUTPUT_PIN_SEL_LSB]))
		else $error("clock select differs from settings");
	backup_gating_a: assert property (@(posedge clk) disable iff (!resetn)
		onBackup_reg |=> !clockOutputEnable && !hostIfEnable)
		else $error("interface or clock output alive in backup");
	backup_write_a: assert property (@(posedge clk) disable iff (!resetn)
		onBackup_reg && regWrite && regAddr == ADDR_NV_SETTINGS && !loadNow |=> $stable(settings_reg))
		else $error("write taken in backup mode");
	switch_over_a: assert property (@(posedge clk) disable iff (!resetn)
		!onBackup_reg && {1'b0, backupSupplyMv} > mainPlusHyst |=> onBackup_reg)
		else $error("no switch to higher backup supply");
	switch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!onBackup_reg && {1'b0, backupSupplyMv} <= mainPlusHyst |=> !onBackup_reg)
		else $error("switched inside hysteresis band");
	thermo_low_a: assert property (@(posedge clk) disable iff (!resetn)
		supplyLowUpperThreshold |=> !thermometerEnable)
		else $error("thermometer on at low supply");
	irq_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		##1 lowUpperIrq == ($past(supplyLowUpperThreshold) && $past(lowUpperIntEnable)))
		else $error("upper low-supply request wrongly gated");
	offset_mag_a: assert property (@(posedge clk) disable iff (!resetn)
		##1 compParams.offsetMag == ($past(offset_reg[6:0]) > OFFSET_MAG_MAX ? OFFSET_MAG_MAX : $past(offset_reg[6:0])))
		else $error("offset magnitude not clamped to range");
	turnover_read_a: assert property (@(posedge clk) disable iff (!resetn)
		hostRead && regAddr == ADDR_CRYSTAL_TURNOVER_TEMP |=> regRdData[7:6] == 2'b00)
		else $error("unused turnover bits read nonzero");
	ram_readback_a: assert property (@(posedge clk) disable iff (!resetn)
		hostWrite && ramHit ##1 hostRead && ramHit && regAddr == $past(regAddr) |=> regRdData == $past(regWrData, 2))
		else $error("user RAM readback mismatch");
	load_copy_a: assert property (@(posedge clk) disable iff (!resetn)
		load_reg == LOAD_WAIT && !supplyLowUpperThreshold |=> ##1 settings_reg == $past(nvPage.settings))
		else $error("settings not loaded from page");
	period_tick_a: assert property (@(posedge clk) disable iff (!resetn)
		monitorTick |-> secCount_reg == '0)
		else $error("tick off the second boundary");
endmodule // rtc_nv_config_and_user_ram

// File: src/rtc_nv_config_pkg.sv
package rtc_nv_config_pkg;

	// ===============================
	// register map
	localparam logic [7:0] ADDR_NV_SETTINGS = 8'h30;
	localparam logic [7:0] ADDR_CRYSTAL_OFFSET = 8'h31;
	localparam logic [7:0] ADDR_CRYSTAL_QUAD_COEF = 8'h32;
	localparam logic [7:0] ADDR_CRYSTAL_TURNOVER_TEMP = 8'h33;
	localparam logic [7:0] ADDR_USER_RAM_FIRST = 8'h38;
	localparam logic [7:0] ADDR_USER_RAM_LAST = 8'h3F;
	localparam logic [4:0] ADDR_USER_RAM_PAGE = 5'h07;
	localparam int USER_RAM_WORDS = 8;
	localparam int USER_RAM_INDEX_W = 3;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [7:0] SETTINGS_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ===============================
	// field layout
	localparam int TRICKLE_MSB = 7;
	localparam int TRICKLE_LSB = 4;
	localparam int CLOCK_OUTPUT_PIN_SEL_MSB = 3;
	localparam int CLOCK_OUTPUT_PIN_SEL_LSB = 2;
	localparam int THERMO_EN_BIT = 1;
	localparam int THERMO_PERIOD_BIT = 0;
	localparam int OFFSET_SIGN_BIT = 7;
	localparam int TURNOVER_W = 6;
	localparam logic [6:0] OFFSET_MAG_MAX = 7'h79;

	// ===============================
	// supply and timing
	localparam int SUPPLY_MV_W = 12;
	localparam logic [12:0] SWITCH_HYST_MV = 13'h0014;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_SECOND = 1000000000;
	localparam int CYCLES_PER_SECOND = NS_PER_SECOND / CLK_PERIOD_NS;
	localparam logic [4:0] MONITOR_SHORT_S = 5'h01;
	localparam logic [4:0] MONITOR_LONG_S = 5'h10;

	// ===============================
	// types
	typedef enum logic [1:0]
	{
		LOAD_WAIT = 2'b00,
		LOAD_COPY = 2'b01,
		LOAD_DONE = 2'b10
	} load_state_e;

	typedef struct packed
	{
		logic [7:0] settings;
		logic [7:0] offset;
		logic [7:0] quadCoef;
		logic [7:0] turnover;
	} nv_page_s;

	typedef struct packed
	{
		logic offsetFast;
		logic [6:0] offsetMag;
		logic [7:0] quadCoef;
		logic [5:0] turnoverTemperature;
	} comp_params_s;

endpackage

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model
(
	input wire logic clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrite,
	output logic regRead,
	input wire logic [7:0] regRdData
);
	// ===============================
	// idle bus
	initial
	begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end

	// ===============================
	// byte access
	// calibration bytes are written only when the bench asks for it
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask

	// write, then read the same byte on the very next cycle
	task wrRd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
		q = regRdData;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		regAddr = ~a;
		@(negedge clk);
		d = regRdData;
	endtask
endmodule // host_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb
	import rtc_nv_config_pkg::*;
;
	logic clk, resetn, regWrite, regRead, supplyLowUpperThreshold, supplyLowLowerThreshold;
	logic lowUpperIntEnable, lowLowerIntEnable, clockOutputEnable, hostIfEnable, onBackup;
	logic thermometerEnable, temperatureWritable, monitorTick, lowUpperIrq, lowLowerIrq, configLoaded;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [SUPPLY_MV_W-1:0] mainSupplyMv, backupSupplyMv;
	logic [3:0] trickleResEn;
	logic [1:0] clkoutFreqSel;
	nv_page_s nvPage;
	comp_params_s compParams;
	int n_fail = 0;
	int checks = 0;
	int n;
	logic [7:0] q;

	rtc_nv_config_and_user_ram #(.CyclesPerSecond(10)) i_rtc_nv_config_and_user_ram (.clk, .resetn, .regAddr,
		.regWrData, .regWrite, .regRead, .regRdData, .nvPage, .mainSupplyMv, .backupSupplyMv,
		.supplyLowUpperThreshold, .supplyLowLowerThreshold, .lowUpperIntEnable, .lowLowerIntEnable,
		.trickleResEn, .clkoutFreqSel, .clockOutputEnable, .hostIfEnable, .onBackup, .thermometerEnable,
		.temperatureWritable, .monitorTick, .compParams, .lowUpperIrq, .lowLowerIrq, .configLoaded);

	host_model i_host_model (.clk, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ===============================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
		end
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host_model.rd(a, d);
		chk({24'h000000, d}, {24'h000000, exp});
	endtask

	task step(input int k);
		repeat (k) @(negedge clk);
	endtask

	// cycles between two ticks, bounded
	task tickGap(output int g);
		g = 0;
		while (monitorTick !== 1'b1 && g < 400)
		begin
			@(negedge clk);
			g++;
		end
		@(negedge clk);
		g = 1;
		while (monitorTick !== 1'b1 && g < 400)
		begin
			@(negedge clk);
			g++;
		end
	endtask

	function automatic logic [7:0] ramVal(input logic [2:0] i);
		return 8'h5A ^ ({5'h00, i} * 8'h13);
	endfunction

	task summarize;
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#100000;
		n_fail++;
		summarize;
	end

	// ===============================
	// tests
	initial
	begin
		resetn = 1'b0;
		nvPage = '{8'hA6, 8'hFF, 8'hC3, 8'hFF};
		mainSupplyMv = 12'hCE4;
		backupSupplyMv = 12'hBB8;
		supplyLowUpperThreshold = 1'b1;
		supplyLowLowerThreshold = 1'b0;
		lowUpperIntEnable = 1'b0;
		lowLowerIntEnable = 1'b0;
		step(20);
		resetn = 1'b1;
		step(3);
		supplyLowUpperThreshold = 1'b0;
		step(5);
		chk(configLoaded, 1'b1);
		rd(8'h30, 8'hA6);
		rd(8'h31, 8'hFF);
		rd(8'h32, 8'hC3);
		rd(8'h33, 8'h3F);
		chk(trickleResEn, 4'hA);
		chk(clkoutFreqSel, 2'h1);
		chk({thermometerEnable, temperatureWritable}, 2'h2);
		chk(compParams, {1'b1, 7'h79, 8'hC3, 6'h3F});
		tickGap(n);
		tickGap(n);
		chk(n, 10);
		i_host_model.wr(8'h31, 8'h05);
		step(3);
		chk(compParams, {1'b0, 7'h05, 8'hC3, 6'h3F});
		i_host_model.wr(8'h30, 8'h59);
		step(3);
		chk({trickleResEn, clkoutFreqSel, thermometerEnable, temperatureWritable}, 8'h59);
		tickGap(n);
		tickGap(n);
		chk(n, 160);
		for (int i = 0; i < 4; i++)
		begin
			i_host_model.wr(8'h30, {4'h1 << i, i[1:0], 2'h2});
			step(3);
			chk({trickleResEn, clkoutFreqSel}, {4'h1 << i, i[1:0]});
		end
		i_host_model.wrRd(8'h3F, 8'hC5, q);
		chk({24'h000000, q}, 32'h000000C5);
		for (int i = 0; i < 8; i++)
			i_host_model.wr(8'h38 + {5'h00, i[2:0]}, ramVal(i[2:0]));
		for (int i = 0; i < 8; i++)
			rd(8'h38 + {5'h00, i[2:0]}, ramVal(i[2:0]));
		rd(8'h34, 8'h00);
		supplyLowUpperThreshold = 1'b1;
		step(2);
		chk({lowUpperIrq, thermometerEnable}, 2'h0);
		lowUpperIntEnable = 1'b1;
		supplyLowLowerThreshold = 1'b1;
		step(2);
		chk({lowUpperIrq, lowLowerIrq}, 2'h2);
		lowLowerIntEnable = 1'b1;
		step(2);
		chk(lowLowerIrq, 1'b1);
		supplyLowUpperThreshold = 1'b0;
		supplyLowLowerThreshold = 1'b0;
		backupSupplyMv = 12'hCF8;
		step(3);
		chk(onBackup, 1'b0);
		backupSupplyMv = 12'hCF9;
		step(3);
		chk({onBackup, hostIfEnable, clockOutputEnable}, 3'h4);
		i_host_model.wr(8'h38, 8'h00);
		i_host_model.wr(8'h30, 8'hFF);
		mainSupplyMv = 12'hD0D;
		step(3);
		chk(onBackup, 1'b1);
		mainSupplyMv = 12'hD0E;
		step(3);
		chk({onBackup, hostIfEnable, clockOutputEnable}, 3'h3);
		rd(8'h38, ramVal(3'h0));
		rd(8'h30, 8'h8E);
		summarize;
	end
endmodule // tb
